// ---- rtl/fcpd_core.sv ----
// What this block does
// RULE_01: Host writes nine bytes for deleted write
// RULE_02: Deleted write moves host data to drive
// RULE_03: Deleted write returns three status, then C,H,R,N
// RULE_04: Recalibrate steps to track zero, then interrupts
// RULE_05: Sense interrupt returns status and present cylinder
// RULE_06: Seek steps selected head to new cylinder
// RULE_07: Register dump returns ten internal bytes
// RULE_08: Sense drive status returns drive status byte
// RULE_09: Unknown opcode: standby, single status 80H
// RULE_10: Bytes pass one at a time through phases
`timescale 1ns/1ps
`include "fcpd_defs.svh"

module fcpd_core #(
  parameter int STEP_CYCLES = `FCPD_STEP_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Command bytes from the host
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_DATA,
  output logic CMD_READY,
  // Result bytes to the host
  output logic RES_VALID,
  output logic [7:0] RES_DATA,
  input wire logic RES_READY,
  // Sector data from the host
  input wire logic HOST_WDATA_VALID,
  input wire logic [7:0] HOST_WDATA,
  output logic HOST_WDATA_READY,
  // Sector data to the drive
  output logic DISK_WDATA_VALID,
  output logic [7:0] DISK_WDATA,
  input wire logic DISK_WDATA_READY,
  // Drive control and status pins
  output logic [1:0] DRIVE_SELECT,
  output logic HEAD_SELECT,
  output logic STEP,
  output logic STEP_DIR,
  output logic WRITE_GATE,
  input wire logic TRACK0,
  input wire logic WRITE_PROTECT,
  input wire logic DRIVE_READY,
  // Controller status
  output logic INTERRUPT,
  output logic STANDBY
);
  import fcpd_pkg::*;

  fcpd_state_type state;
  fcpd_kind_type kind, kind_now;
  logic [7:0] cmd_buf [0:`FCPD_CMD_DEPTH-1];
  logic [7:0] res_buf [0:`FCPD_RES_DEPTH-1];
  logic [7:0] present_cylinder [0:3];
  logic [3:0] cmd_cnt, res_cnt;
  logic [7:0] int_st0, step_count;
  logic [14:0] xfer_len, in_cnt, out_cnt;
  logic [31:0] step_timer;
  logic [2:0] pin_meta, pin_sync;
  logic [1:0] int_drive, drive;
  logic int_pending, standby, step_out, step_dir, head;
  logic cmd_fire, cmd_last, res_fire, step_tick, at_target, step_done;
  logic write_done, fifo_in_ready, fifo_in_valid, disk_fire;
  // Pins from the drive cross into the clock domain here
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {TRACK0, WRITE_PROTECT, DRIVE_READY};
      pin_sync <= pin_meta;
    end
  end
  assign drive = cmd_buf[`FCPD_B_SEL][1:0];
  assign head = cmd_buf[`FCPD_B_SEL][2];
  assign CMD_READY = (state == ST_CMD); // RULE_10
  assign cmd_fire = CMD_VALID && CMD_READY;
  assign kind_now = (cmd_cnt == 4'h0) ? fcpd_decode(CMD_DATA) : kind;
  assign cmd_last = cmd_fire && ((cmd_cnt + 4'h1) == fcpd_cmd_len(kind_now)); // RULE_01
  assign RES_VALID = (state == ST_RESULT); // RULE_10
  assign RES_DATA = res_buf[0];
  assign res_fire = RES_VALID && RES_READY;
  // Sector length: size code zero means the data length byte applies
  assign xfer_len = (cmd_buf[`FCPD_B_SIZE][2:0] == 3'h0) ? {7'h00, cmd_buf[`FCPD_B_DTL]} :
                    (`FCPD_SECTOR_BASE << cmd_buf[`FCPD_B_SIZE][2:0]);
  assign write_done = (state == ST_WRITE) && (out_cnt == xfer_len);
  assign fifo_in_valid = HOST_WDATA_VALID && (state == ST_WRITE) && (in_cnt != xfer_len);
  assign HOST_WDATA_READY = fifo_in_ready && (state == ST_WRITE) && (in_cnt != xfer_len); // RULE_02
  assign disk_fire = DISK_WDATA_VALID && DISK_WDATA_READY;
  assign WRITE_GATE = (state == ST_WRITE);
  assign step_tick = (state == ST_STEP) && (step_timer == 32'h0000_0000);
  assign at_target = (kind == K_RECAL) ? (pin_sync[2] || step_count == `FCPD_MAX_STEPS) :
                     (present_cylinder[drive] == cmd_buf[`FCPD_B_CYL]);
  assign step_done = step_tick && at_target;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_CMD;
    end else begin
      unique case (state)
        ST_CMD: begin
          if (cmd_last) begin
            unique case (kind_now)
              K_WDD: state <= ST_WRITE;
              K_RECAL, K_SEEK: state <= ST_STEP;
              default: state <= ST_LOAD;
            endcase
          end
        end
        ST_WRITE: if (write_done) state <= ST_LOAD;
        ST_STEP: if (step_done) state <= ST_CMD; // RULE_04 RULE_06
        ST_LOAD: state <= ST_RESULT;
        ST_RESULT: if (res_fire && res_cnt == 4'h1) state <= ST_CMD;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cmd_cnt <= '0;
      kind <= K_INV;
      for (int i = 0; i < `FCPD_CMD_DEPTH; i++) cmd_buf[i] <= '0;
    end else if (cmd_fire) begin
      cmd_buf[cmd_cnt] <= CMD_DATA;
      kind <= kind_now;
      cmd_cnt <= cmd_last ? 4'h0 : cmd_cnt + 4'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      standby <= 1'b0;
    end else if (cmd_last) begin
      standby <= (kind_now == K_INV); // RULE_09
    end
  end
  assign STANDBY = standby;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      in_cnt <= '0;
      out_cnt <= '0;
    end else if (cmd_last) begin
      in_cnt <= '0;
      out_cnt <= '0;
    end else begin
      if (fifo_in_valid && fifo_in_ready) in_cnt <= in_cnt + 15'h0001;
      if (disk_fire) out_cnt <= out_cnt + 15'h0001; // RULE_02
    end
  end

  // Drain stalls propagate back to the host through the FIFO ready
  fcpd_fifo #(
    .WIDTH(8),
    .DEPTH(`FCPD_FIFO_DEPTH)
  ) u_fifo (
    .clock(CLOCK),
    .rstn(RSTN),
    .in_valid(fifo_in_valid),
    .in_data(HOST_WDATA),
    .in_ready(fifo_in_ready),
    .out_valid(DISK_WDATA_VALID),
    .out_data(DISK_WDATA),
    .out_ready(DISK_WDATA_READY)
  );
  // One step per period; on a seek the cylinder count tracks each pulse, a recalibrate zeroes it at the end
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      step_timer <= '0;
      step_count <= '0;
      step_out <= 1'b0;
      step_dir <= 1'b0;
      for (int i = 0; i < 4; i++) present_cylinder[i] <= '0;
    end else if (cmd_last) begin
      step_timer <= `FCPD_SELECT_SETTLE; // RULE_04
      step_count <= '0;
    end else if (step_tick) begin
      if (at_target) begin
        if (kind == K_RECAL) present_cylinder[drive] <= '0; // RULE_04
      end else begin
        step_timer <= 32'(STEP_CYCLES - 1);
        step_count <= step_count + 8'h01;
        step_out <= 1'b1;
        if (kind == K_RECAL) begin
          step_dir <= 1'b0; // RULE_04
        end else if (cmd_buf[`FCPD_B_CYL] > present_cylinder[drive]) begin
          step_dir <= 1'b1;
          present_cylinder[drive] <= present_cylinder[drive] + 8'h01; // RULE_06
        end else begin
          step_dir <= 1'b0;
          present_cylinder[drive] <= present_cylinder[drive] - 8'h01; // RULE_06
        end
      end
    end else if (state == ST_STEP) begin
      step_timer <= step_timer - 32'h0000_0001;
      if (step_timer == 32'(STEP_CYCLES - `FCPD_STEP_PULSE_CYCLES)) step_out <= 1'b0;
    end
  end
  assign STEP = step_out;
  assign STEP_DIR = step_dir;
  assign DRIVE_SELECT = drive;
  assign HEAD_SELECT = head;
  // A completion in the same cycle as a sense command still raises the flag
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      int_pending <= 1'b0;
      int_st0 <= '0;
      int_drive <= '0;
    end else if (step_done) begin
      int_pending <= 1'b1; // RULE_04
      int_st0 <= {`FCPD_ST0_SEEK_END, (kind == K_SEEK) && head, drive};
      int_drive <= drive;
    end else if (state == ST_LOAD && kind == K_SIS) begin
      int_pending <= 1'b0; // RULE_05
    end
  end
  assign INTERRUPT = int_pending;
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      res_cnt <= '0;
      for (int i = 0; i < `FCPD_RES_DEPTH; i++) res_buf[i] <= '0;
    end else if (state == ST_LOAD) begin
      for (int i = 0; i < `FCPD_RES_DEPTH; i++) res_buf[i] <= `FCPD_ST_CLEAR;
      unique case (kind)
        K_WDD: begin
          res_buf[0] <= {`FCPD_ST0_NORMAL, head, drive}; // RULE_03
          res_buf[3] <= cmd_buf[`FCPD_B_CYL];
          res_buf[4] <= cmd_buf[`FCPD_B_HEAD];
          res_buf[5] <= cmd_buf[`FCPD_B_SECT];
          res_buf[6] <= cmd_buf[`FCPD_B_SIZE];
          res_cnt <= `FCPD_RES_WDD;
        end
        K_SIS: begin
          // Without a pending event the answer is the invalid status
          res_buf[0] <= int_pending ? int_st0 : `FCPD_ST_INVALID; // RULE_05
          res_buf[1] <= present_cylinder[int_drive];
          res_cnt <= `FCPD_RES_SIS;
        end
        K_DUMP: begin
          for (int i = 0; i < 4; i++) res_buf[i] <= present_cylinder[i]; // RULE_07
          res_buf[4] <= `FCPD_DUMP_TIMING1;
          res_buf[5] <= `FCPD_DUMP_TIMING2;
          res_buf[6] <= `FCPD_DUMP_SECTORS;
          res_buf[7] <= `FCPD_DUMP_LOCK;
          res_buf[8] <= `FCPD_DUMP_CONFIG;
          res_buf[9] <= `FCPD_DUMP_PRETRK;
          res_cnt <= `FCPD_RES_DUMP;
        end
        K_SDS: begin
          res_buf[0] <= {1'b0, pin_sync[1], pin_sync[0], pin_sync[2], 1'b0, head, drive}; // RULE_08
          res_cnt <= `FCPD_RES_ONE;
        end
        default: begin
          res_buf[0] <= `FCPD_ST_INVALID; // RULE_09
          res_cnt <= `FCPD_RES_ONE;
        end
      endcase
    end else if (res_fire) begin
      for (int i = 0; i < `FCPD_RES_DEPTH - 1; i++) res_buf[i] <= res_buf[i+1]; // RULE_10
      res_cnt <= res_cnt - 4'h1;
    end
  end

  sequence s_load_of(fcpd_kind_type k);
    state == ST_LOAD && kind == k;
  endsequence
  sequence s_result_len(logic [3:0] n);
    RES_VALID && res_cnt == n;
  endsequence
  a_wdd_result_seven: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_03
    s_load_of(K_WDD) |=> s_result_len(`FCPD_RES_WDD) ##0 RES_DATA[1:0] == $past(drive))
    else $error("Deleted write result is not seven bytes");
  a_sis_two_bytes: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_05
    s_load_of(K_SIS) |=> s_result_len(`FCPD_RES_SIS) ##0 !INTERRUPT)
    else $error("Sense interrupt result wrong");
  a_dump_ten_bytes: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_07
    s_load_of(K_DUMP) |=> s_result_len(`FCPD_RES_DUMP) ##0 RES_DATA == $past(present_cylinder[0]))
    else $error("Register dump result wrong");
  a_sds_one_byte: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_08
    s_load_of(K_SDS) |=> s_result_len(`FCPD_RES_ONE) ##0 RES_DATA[2:0] == $past({head, drive}))
    else $error("Drive status result wrong");
  a_invalid_status: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_09
    s_load_of(K_INV) |=> s_result_len(`FCPD_RES_ONE) ##0 RES_DATA == `FCPD_ST_INVALID && STANDBY)
    else $error("Invalid opcode not answered with 80H");
  a_step_done_irq: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_04
    step_done |=> INTERRUPT && CMD_READY && !RES_VALID)
    else $error("Positioning end without interrupt");
  a_seek_reached: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_06
    step_done && kind == K_SEEK |-> present_cylinder[drive] == cmd_buf[`FCPD_B_CYL])
    else $error("Seek ended off target");
  a_write_gated: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_02
    disk_fire |-> WRITE_GATE && out_cnt < xfer_len)
    else $error("Drive data moved outside write phase");
  a_phase_exclusive: assert property (@(posedge CLOCK) disable iff (!RSTN) // RULE_10
    !(CMD_READY && RES_VALID) && !($past(cmd_last) && CMD_READY))
    else $error("Command and result phases overlap");
endmodule : fcpd_core

// ---- rtl/fcpd_defs.svh ----
`ifndef FCPD_DEFS_SVH
`define FCPD_DEFS_SVH

// Opcodes; write deleted data ignores the two top option bits
`define FCPD_OP_WDD_MASK 8'h3F
`define FCPD_OP_WDD 8'h09
`define FCPD_OP_RECAL 8'h07
`define FCPD_OP_SIS 8'h08
`define FCPD_OP_SEEK 8'h0F
`define FCPD_OP_DUMP 8'h0E
`define FCPD_OP_SDS 8'h04

// Command lengths in bytes, opcode included
`define FCPD_LEN_WDD 4'h9
`define FCPD_LEN_RECAL 4'h2
`define FCPD_LEN_SEEK 4'h3
`define FCPD_LEN_SDS 4'h2
`define FCPD_LEN_ONE 4'h1

// Result lengths in bytes
`define FCPD_RES_WDD 4'h7
`define FCPD_RES_SIS 4'h2
`define FCPD_RES_DUMP 4'hA
`define FCPD_RES_ONE 4'h1

// Command byte positions
`define FCPD_B_OP 0
`define FCPD_B_SEL 1
`define FCPD_B_CYL 2
`define FCPD_B_HEAD 3
`define FCPD_B_SECT 4
`define FCPD_B_SIZE 5
`define FCPD_B_EOT 6
`define FCPD_B_GAP 7
`define FCPD_B_DTL 8
`define FCPD_CMD_DEPTH 9
`define FCPD_RES_DEPTH 10

// Status values
`define FCPD_ST0_NORMAL 5'h00
`define FCPD_ST0_SEEK_END 5'h08
`define FCPD_ST_INVALID 8'h80
`define FCPD_ST_CLEAR 8'h00

// Register dump values of the sections not built here
`define FCPD_DUMP_TIMING1 8'h00
`define FCPD_DUMP_TIMING2 8'h00
`define FCPD_DUMP_SECTORS 8'h00
`define FCPD_DUMP_LOCK 8'h00
`define FCPD_DUMP_CONFIG 8'h00
`define FCPD_DUMP_PRETRK 8'h00

// Transfer sizing
`define FCPD_SECTOR_BASE 15'h0080
`define FCPD_FIFO_DEPTH 16
`define FCPD_MAX_STEPS 8'h50

// Head stepping timing
`define FCPD_CLK_PERIOD_NS 5
`define FCPD_STEP_TIME_NS 3000000
`define FCPD_STEP_PULSE_NS 1000
// Synchronised pins lag a new drive select; the first head decision waits for them
`define FCPD_SELECT_SETTLE 32'h0000_0003
`define FCPD_STEP_CYCLES (`FCPD_STEP_TIME_NS / `FCPD_CLK_PERIOD_NS)
`define FCPD_STEP_PULSE_CYCLES ((`FCPD_STEP_PULSE_NS + `FCPD_CLK_PERIOD_NS - 1) / `FCPD_CLK_PERIOD_NS)

`endif

// ---- rtl/fcpd_pkg.sv ----
`include "fcpd_defs.svh"

package fcpd_pkg;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_WRITE = 3'b001,
    ST_STEP = 3'b010,
    ST_LOAD = 3'b011,
    ST_RESULT = 3'b100
  } fcpd_state_type;

  typedef enum logic [2:0] {
    K_WDD = 3'b000,
    K_RECAL = 3'b001,
    K_SIS = 3'b010,
    K_SEEK = 3'b011,
    K_DUMP = 3'b100,
    K_SDS = 3'b101,
    K_INV = 3'b110
  } fcpd_kind_type;

  function automatic fcpd_kind_type fcpd_decode(input logic [7:0] op);
    if ((op & `FCPD_OP_WDD_MASK) == `FCPD_OP_WDD) return K_WDD;
    else if (op == `FCPD_OP_RECAL) return K_RECAL;
    else if (op == `FCPD_OP_SIS) return K_SIS;
    else if (op == `FCPD_OP_SEEK) return K_SEEK;
    else if (op == `FCPD_OP_DUMP) return K_DUMP;
    else if (op == `FCPD_OP_SDS) return K_SDS;
    else return K_INV;
  endfunction : fcpd_decode

  function automatic logic [3:0] fcpd_cmd_len(input fcpd_kind_type k);
    unique case (k)
      K_WDD: return `FCPD_LEN_WDD;
      K_RECAL: return `FCPD_LEN_RECAL;
      K_SEEK: return `FCPD_LEN_SEEK;
      K_SDS: return `FCPD_LEN_SDS;
      default: return `FCPD_LEN_ONE;
    endcase
  endfunction : fcpd_cmd_len

endpackage : fcpd_pkg

// ---- rtl/fcpd_fifo.sv ----
`timescale 1ns/1ps

module fcpd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty when the indices meet
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clock) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clock) disable iff (!rstn)
    (wr_ptr - rd_ptr) <= (AW+1)'(DEPTH))
    else $error("FIFO holds more words than its depth");

endmodule : fcpd_fifo

// ---- bench/fcpd_host.sv ----
`timescale 1ns/1ps

module fcpd_host (
  // Clock
  input wire logic clock,
  // Command and result bytes
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic res_valid,
  input wire logic [7:0] res_data,
  output logic res_ready,
  // Sector data
  output logic wr_valid,
  output logic [7:0] wr_data,
  input wire logic wr_ready
);
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  int accepted;
  int timeouts;

  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    res_ready = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    accepted = 0;
    timeouts = 0;
  end

  // Each byte is held until the edge that takes it
  task automatic send(input logic [7:0] b[$]);
    int n;
    foreach (b[i]) begin
      cmd_valid <= 1'b1;
      cmd_data <= b[i];
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (cmd_ready !== 1'b1 && n < 5000);
      if (cmd_ready !== 1'b1) timeouts++;
    end
    cmd_valid <= 1'b0;
    cmd_data <= ~b[b.size()-1];
  endtask : send

  // Result bytes are taken strictly in the order offered
  task automatic pop(input int cnt);
    int k;
    k = 0;
    rq.delete();
    res_ready <= 1'b1;
    while (rq.size() < cnt && k < 5000) begin
      @(posedge clock);
      k++;
      if (res_valid === 1'b1) rq.push_back(res_data);
    end
    res_ready <= 1'b0;
  endtask : pop

  // Idle data line toggles so a stale byte never looks fresh
  always @(posedge clock) begin
    if (wr_valid && wr_ready) begin
      void'(wq.pop_front());
      accepted++;
    end
    wr_valid <= (wq.size() > 0);
    wr_data <= (wq.size() > 0) ? wq[0] : ~wr_data;
  end
endmodule : fcpd_host

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "fcpd_defs.svh"

module tb_top;
  localparam logic [7:0] BAD_OPS [4] = '{8'h00, 8'h01, 8'h1F, 8'hFF};
  logic clock, rstn, stall, step_d;
  logic cmd_valid, cmd_ready, res_valid, res_ready, hw_valid, hw_ready, dw_valid, dw_ready;
  logic [7:0] cmd_data, res_data, hw_data, dw_data;
  logic [1:0] drive_sel;
  logic head_sel, step, step_dir, write_gate, track0, wprot, drv_ready, interrupt, standby;
  int mismatches, samples_checked;
  int pos[4];
  int present_cylinder[4];
  logic [7:0] dq[$];
  logic [7:0] exp[$];

  // Short step period keeps seeks within a few thousand cycles
  fcpd_core #(.STEP_CYCLES(300)) dut_u (
    .CLOCK(clock), .RSTN(rstn),
    .CMD_VALID(cmd_valid), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
    .RES_VALID(res_valid), .RES_DATA(res_data), .RES_READY(res_ready),
    .HOST_WDATA_VALID(hw_valid), .HOST_WDATA(hw_data), .HOST_WDATA_READY(hw_ready),
    .DISK_WDATA_VALID(dw_valid), .DISK_WDATA(dw_data), .DISK_WDATA_READY(dw_ready),
    .DRIVE_SELECT(drive_sel), .HEAD_SELECT(head_sel), .STEP(step), .STEP_DIR(step_dir),
    .WRITE_GATE(write_gate), .TRACK0(track0), .WRITE_PROTECT(wprot), .DRIVE_READY(drv_ready),
    .INTERRUPT(interrupt), .STANDBY(standby)
  );

  fcpd_host host_u (
    .clock(clock), .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
    .wr_valid(hw_valid), .wr_data(hw_data), .wr_ready(hw_ready)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Head position of each drive, moved by step pulses
  always @(posedge clock) begin
    step_d <= step;
    if (step === 1'b1 && step_d === 1'b0) pos[drive_sel] = pos[drive_sel] + (step_dir ? 1 : -1);
    track0 <= (pos[drive_sel] == 0);
  end

  // Drive side takes bytes with random stalls
  always @(posedge clock) begin
    if (dw_valid === 1'b1 && dw_ready) dq.push_back(dw_data);
    dw_ready <= !stall && ($urandom % 4 != 0);
  end

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t byte exp=%h got=%h", $time, e, g);
    end
  endtask : chk_byte

  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t value exp=%h got=%h", $time, e, g);
    end
  endtask : chk_val

  task automatic get_res(input int n);
    host_u.pop(n);
    chk_val(n, host_u.rq.size());
    foreach (exp[i]) chk_byte(exp[i], host_u.rq[i]);
    exp.delete();
  endtask : get_res

  task automatic wait_int();
    int n;
    n = 0;
    while (interrupt !== 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    if (interrupt !== 1'b1) mismatches++;
  endtask : wait_int

  task automatic finish_test();
    mismatches += host_u.timeouts;
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    mismatches++;
    finish_test();
  end

  initial begin
    logic [7:0] c, h, r, g;
    logic [7:0] sent[$];
    int d, hd, n, len;
    void'($urandom(54));
    rstn = 1'b0;
    stall = 1'b0;
    step_d = 1'b0;
    track0 = 1'b1;
    wprot = 1'b0;
    drv_ready = 1'b1;
    dw_ready = 1'b0;
    pos = '{default: 0};
    present_cylinder = '{default: 0};
    repeat (12) @(posedge clock);
    chk_val(5'b10000, {cmd_ready, res_valid, step, interrupt, standby});
    rstn <= 1'b1;
    @(posedge clock);
    host_u.send('{`FCPD_OP_SIS});
    exp = '{`FCPD_ST_INVALID, 8'h00};
    get_res(2);
    for (d = 0; d < 4; d++) begin
      hd = $urandom % 2;
      n = 1 + $urandom % 6;
      host_u.send('{`FCPD_OP_SEEK, 8'(hd * 4 + d), 8'(n)});
      wait_int();
      chk_val(n, pos[d]);
      present_cylinder[d] = n;
      host_u.send('{`FCPD_OP_SIS});
      exp = '{{`FCPD_ST0_SEEK_END, 3'(hd * 4 + d)}, 8'(n)};
      get_res(2);
      chk_val(0, interrupt);
    end
    host_u.send('{`FCPD_OP_DUMP});
    foreach (present_cylinder[i]) exp.push_back(8'(present_cylinder[i]));
    repeat (6) exp.push_back(8'h00);
    get_res(10);
    host_u.send('{`FCPD_OP_RECAL, 8'h02});
    wait_int();
    chk_val(0, pos[2]);
    host_u.send('{`FCPD_OP_SIS});
    exp = '{{`FCPD_ST0_SEEK_END, 3'h2}, 8'h00};
    get_res(2);
    repeat (2) begin
      wprot <= 1'($urandom % 2);
      drv_ready <= 1'($urandom % 2);
      hd = $urandom % 2;
      repeat (4) @(posedge clock);
      host_u.send('{`FCPD_OP_SDS, 8'(hd * 4 + 2)});
      exp = '{{1'b0, wprot, drv_ready, 1'b1, 1'b0, hd[0], 2'd2}};
      get_res(1);
      chk_val(hd * 4 + 2, {head_sel, drive_sel});
    end
    foreach (BAD_OPS[i]) begin
      host_u.send('{BAD_OPS[i]});
      exp = '{`FCPD_ST_INVALID};
      get_res(1);
      chk_val(1, standby);
    end
    for (n = 0; n < 2; n++) begin
      d = $urandom % 4;
      hd = $urandom % 2;
      c = 8'($urandom);
      h = 8'($urandom);
      r = 8'($urandom);
      g = 8'($urandom);
      len = n ? 17 : 40;
      host_u.wq.delete();
      dq.delete();
      repeat (len) host_u.wq.push_back(8'($urandom));
      sent = host_u.wq;
      host_u.accepted = 0;
      stall <= (n == 0);
      host_u.send('{n ? 8'hC9 : 8'h09, 8'(hd * 4 + d), c, h, r, 8'h00, g, ~g, 8'(len)});
      if (n == 0) begin
        // With the drive stalled the buffer must fill and then refuse
        repeat (60) @(posedge clock);
        chk_val(16, host_u.accepted);
        chk_val(2'b10, {write_gate, hw_ready});
        stall <= 1'b0;
      end
      exp = '{8'(hd * 4 + d), 8'h00, 8'h00, c, h, r, 8'h00};
      get_res(7);
      chk_val(len, dq.size());
      foreach (sent[i]) chk_byte(sent[i], dq[i]);
      chk_val(0, standby);
    end
    finish_test();
  end
endmodule : tb_top
